// ==== shared/ocsq_pkg.sv ====
// Purpose: shared constants and types of the octal channel serial sequencer
// Assumes: one conversion spans a group of 16 serial clock edges
// Notes:   positions count rising edges seen in the current group (0..15)
package ocsq_pkg;

    localparam int RES_W  = 12;
    localparam int CTRL_W = 8;
    localparam int CHAN_W = 3;
    localparam int POS_W  = 4;

    // group position at a falling edge is (falling edge number - 1)
    localparam logic [POS_W-1:0] POS_FIRST      = 4'h0;
    localparam logic [POS_W-1:0] POS_HOLD       = 4'h3;
    localparam logic [POS_W-1:0] POS_FIRST_DATA = 4'h4;
    localparam logic [POS_W-1:0] POS_LAST       = 4'hF;
    // rising edge 8 of a group is seen with a count of 7
    localparam logic [POS_W-1:0] POS_CTRL_LAST  = 4'h7;

    // control word field
    localparam int CHAN_MSB = 5;
    localparam int CHAN_LSB = 3;
    localparam logic [CHAN_W-1:0] CHAN_RESET = 3'h0;

    localparam logic [CTRL_W-1:0] CTRL_RESET = 8'h00;
    localparam logic [RES_W-1:0]  CODE_RESET = 12'h000;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'b00,
        PH_TRACK = 2'b01,
        PH_HOLD  = 2'b10,
        PH_GAP   = 2'b11
    } ocsq_phase_e;

    typedef struct packed {
        logic [CHAN_W-1:0] chan;
        logic [RES_W-1:0]  code;
    } ocsq_result_s;

    localparam ocsq_result_s RESULT_RESET = '{chan: CHAN_RESET, code: CODE_RESET};

endpackage : ocsq_pkg

// ==== rtl/ocsq_sync.sv ====
// Purpose: two flip-flop synchroniser, one chain per bit
// Assumes: inputs are levels or toggles held long enough to be seen
// Notes:   first stage feeds only the second stage
module ocsq_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    if (WIDTH < 1) begin : g_check
        $error("ocsq_sync needs WIDTH of at least one");
    end

    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        logic meta_q;
        always_ff @(posedge clk or negedge rst_n) begin
            if (!rst_n) begin
                meta_q      <= 1'b0;
                sync_out[i] <= 1'b0;
            end else begin
                meta_q      <= async_in[i];
                sync_out[i] <= meta_q;
            end
        end
    end

endmodule : ocsq_sync

// ==== rtl/ocsq_rise_side.sv ====
// Purpose: rising edge logic of the link: group counter and control word
// Assumes: chip select high clears framing; resetn is the power-on reset
// Notes:   the channel code survives frames, only resetn clears it
module ocsq_rise_side (
    input  wire logic                              serial_clock,
    input  wire logic                              chip_select_n,
    input  wire logic                              resetn,
    input  wire logic                              serial_in,
    output logic      [ocsq_pkg::POS_W-1:0]        rise_pos_q,
    output logic      [ocsq_pkg::CHAN_W-1:0]       next_chan_q
);

    logic [ocsq_pkg::CTRL_W-1:0] next_channel_control_q;

    // framing state is held in reset while chip select is high
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            rise_pos_q <= ocsq_pkg::POS_FIRST;
        end else begin
            rise_pos_q <= rise_pos_q + 4'h1; // wraps every 16 rises
        end
    end

    // bit 7 arrives first and ends up at the top
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            next_channel_control_q <= ocsq_pkg::CTRL_RESET;
        end else if (rise_pos_q <= ocsq_pkg::POS_CTRL_LAST) begin
            next_channel_control_q <= {next_channel_control_q[ocsq_pkg::CTRL_W-2:0], serial_in};
        end
    end

    // commit on the 8th rise; a short frame leaves the old code
    always_ff @(posedge serial_clock or negedge resetn) begin
        if (!resetn) begin
            next_chan_q <= ocsq_pkg::CHAN_RESET;
        end else if (!chip_select_n && rise_pos_q == ocsq_pkg::POS_CTRL_LAST) begin
            // seven bits shifted so far: word bits 5..3 sit one place lower
            next_chan_q <= next_channel_control_q[ocsq_pkg::CHAN_MSB-1:ocsq_pkg::CHAN_LSB-1];
        end
    end

endmodule : ocsq_rise_side

// ==== rtl/ocsq_top.sv ====
// Purpose: serial port sequencer of an eight input 12-bit converter
// Assumes: serial_clock is the link clock; mclk runs the status side
// Notes:   sar_code comes from the converter core, valid by falling edge 5
//
// Function
// - a frame starts on chip select falling and ends on it rising
// - serial_out driven while chip select low, released while high
// - clock activity is ignored while chip select is high
// - track for 3 clock cycles, then hold and convert for 12, then a 1 cycle gap
// - falls 1 to 4 send zeros, falls 5 to 16 send result MSB first
// - each new 16 edge group tracks again and holds on its 4th fall
// - chip select falling with clock high: track at first clock fall
// - chip select falling with clock low: track now, counts as first fall
// - chip select and clock falling together: enter track
// - chip select and clock rising edges may come in any order
// - first 8 rising edges of a conversion capture the control word
// - bits 5 to 3 are the channel, other bits ignored
// - channel code 0 to 7 selects input 0 to 7
// - first conversion after power-up is valid and uses input 0
// - result is unsigned straight binary over 4096 codes
// - powered while chip select low, down while high
// - continuous mode powers down from fall 16 to next first fall
module ocsq_top (
    input  wire logic                           mclk,
    input  wire logic                           resetn,
    input  wire logic                           chip_select_n,
    input  wire logic                           serial_clock,
    input  wire logic                           serial_in,
    output logic                                serial_out,
    output logic                                serial_out_en,
    input  wire logic [ocsq_pkg::RES_W-1:0]     sar_code,
    output logic                                track_en,
    output logic                                hold_en,
    output logic      [ocsq_pkg::CHAN_W-1:0]    mux_channel,
    output logic                                powered_up,
    output logic                                result_valid,
    output ocsq_pkg::ocsq_result_s              result,
    output logic                                result_overrun,
    output logic                                link_powered,
    output logic                                frame_active
);

    ////////////////////////////////////////////////////////////////////////////
    // link side, rising edges

    logic [ocsq_pkg::POS_W-1:0]  rise_pos_q;
    logic [ocsq_pkg::CHAN_W-1:0] next_chan_q;

    ocsq_rise_side u_rise (
        .serial_clock  (serial_clock),
        .chip_select_n (chip_select_n),
        .resetn        (resetn),
        .serial_in     (serial_in),
        .rise_pos_q    (rise_pos_q),
        .next_chan_q   (next_chan_q)
    );

    ////////////////////////////////////////////////////////////////////////////
    // link side, falling edges

    ocsq_pkg::ocsq_phase_e        phase_q;
    ocsq_pkg::ocsq_phase_e        phase_d;
    logic                         cs_fell_low_q;
    logic                         dout_q;
    logic [ocsq_pkg::RES_W-1:0]   code_q;
    logic [ocsq_pkg::CHAN_W-1:0]  conv_chan_q;
    logic [ocsq_pkg::POS_W-1:0]   bit_idx;
    logic                         started;

    // clock level at the chip select fall; low means that fall is edge 1
    always_ff @(negedge chip_select_n or negedge resetn) begin
        if (!resetn) begin
            cs_fell_low_q <= 1'b0;
        end else begin
            cs_fell_low_q <= ~serial_clock;
        end
    end

    always_comb begin
        phase_d = phase_q;
        case (phase_q)
            ocsq_pkg::PH_IDLE: begin
                phase_d = ocsq_pkg::PH_TRACK;
            end
            ocsq_pkg::PH_TRACK: begin
                if (rise_pos_q == ocsq_pkg::POS_HOLD) begin
                    phase_d = ocsq_pkg::PH_HOLD;
                end
            end
            ocsq_pkg::PH_HOLD: begin
                if (rise_pos_q == ocsq_pkg::POS_LAST) begin
                    phase_d = ocsq_pkg::PH_GAP;
                end
            end
            ocsq_pkg::PH_GAP: begin
                phase_d = ocsq_pkg::PH_TRACK;
            end
            default: begin
                phase_d = ocsq_pkg::PH_IDLE;
            end
        endcase
    end

    // chip select high gates the clock off and clears framing
    always_ff @(negedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            phase_q <= ocsq_pkg::PH_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // result bits sit at positions 4..15, the MSB at position 4
    assign bit_idx = ocsq_pkg::POS_LAST - rise_pos_q;

    always_ff @(negedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n) begin
            dout_q <= 1'b0;
        end else if (rise_pos_q < ocsq_pkg::POS_FIRST_DATA) begin
            dout_q <= 1'b0;
        end else if (rise_pos_q == ocsq_pkg::POS_FIRST_DATA) begin
            dout_q <= sar_code[ocsq_pkg::RES_W-1];
        end else begin
            dout_q <= code_q[bit_idx];
        end
    end

    // code frozen at fall 5 so a late core change cannot tear the word
    always_ff @(negedge serial_clock or negedge resetn) begin
        if (!resetn) begin
            code_q <= ocsq_pkg::CODE_RESET;
        end else if (!chip_select_n && rise_pos_q == ocsq_pkg::POS_FIRST_DATA) begin
            code_q <= sar_code;
        end
    end

    // channel of the sample just held, for the status side
    always_ff @(negedge serial_clock or negedge resetn) begin
        if (!resetn) begin
            conv_chan_q <= ocsq_pkg::CHAN_RESET;
        end else if (!chip_select_n && rise_pos_q == ocsq_pkg::POS_HOLD) begin
            conv_chan_q <= next_chan_q;
        end
    end

    // output enable follows chip select only, so no clock is needed to release
    assign serial_out    = dout_q;
    assign serial_out_en = ~chip_select_n;

    ////////////////////////////////////////////////////////////////////////////
    // converter core controls

    assign started = (phase_q != ocsq_pkg::PH_IDLE) | cs_fell_low_q;

    always_comb begin
        track_en = 1'b0;
        hold_en  = 1'b0;
        if (!chip_select_n) begin
            case (phase_q)
                ocsq_pkg::PH_IDLE: begin
                    track_en = started;
                end
                ocsq_pkg::PH_TRACK: begin
                    track_en = 1'b1;
                end
                ocsq_pkg::PH_HOLD: begin
                    hold_en = 1'b1;
                end
                ocsq_pkg::PH_GAP: begin
                    hold_en = 1'b0;
                end
                default: begin
                    track_en = 1'b0;
                end
            endcase
        end
    end

    // plain binary index straight onto the input mux
    assign mux_channel = next_chan_q;

    // the gap after fall 16 is the only low chip select power-down
    assign powered_up = ~chip_select_n & (phase_q != ocsq_pkg::PH_GAP);

    ////////////////////////////////////////////////////////////////////////////
    // result hand-off to the mclk side

    ocsq_pkg::ocsq_result_s  pub_q;
    logic                    req_tgl_q;
    logic                    ovr_tgl_q;
    logic                    ack_sync;
    logic                    ack_tgl_q;
    logic                    xfer_idle;

    // ack only advances on link edges; a stopped clock just delays it
    ocsq_sync #(
        .WIDTH (1)
    ) u_ack_sync (
        .clk      (serial_clock),
        .rst_n    (resetn),
        .async_in (ack_tgl_q),
        .sync_out (ack_sync)
    );

    assign xfer_idle = (req_tgl_q == ack_sync);

    // a result arriving before the last is taken is dropped and flagged
    always_ff @(negedge serial_clock or negedge resetn) begin
        if (!resetn) begin
            pub_q     <= ocsq_pkg::RESULT_RESET;
            req_tgl_q <= 1'b0;
        end else if (!chip_select_n && rise_pos_q == ocsq_pkg::POS_LAST && xfer_idle) begin
            pub_q.chan <= conv_chan_q;
            pub_q.code <= code_q;
            req_tgl_q  <= ~req_tgl_q;
        end
    end

    always_ff @(negedge serial_clock or negedge resetn) begin
        if (!resetn) begin
            ovr_tgl_q <= 1'b0;
        end else if (!chip_select_n && rise_pos_q == ocsq_pkg::POS_LAST && !xfer_idle) begin
            ovr_tgl_q <= ~ovr_tgl_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // mclk side status

    logic [3:0] mc_sync;
    logic       req_seen_q;
    logic       ovr_seen_q;

    ocsq_sync #(
        .WIDTH (4)
    ) u_mclk_sync (
        .clk      (mclk),
        .rst_n    (resetn),
        .async_in ({req_tgl_q, ovr_tgl_q, powered_up, ~chip_select_n}),
        .sync_out (mc_sync)
    );

    // pub_q is stable while the request toggle is unanswered
    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            req_seen_q   <= 1'b0;
            ack_tgl_q    <= 1'b0;
            result_valid <= 1'b0;
            result       <= ocsq_pkg::RESULT_RESET;
        end else begin
            req_seen_q   <= mc_sync[3];
            result_valid <= mc_sync[3] ^ req_seen_q;
            if (mc_sync[3] ^ req_seen_q) begin
                result    <= pub_q;
                ack_tgl_q <= mc_sync[3];
            end
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            ovr_seen_q     <= 1'b0;
            result_overrun <= 1'b0;
        end else begin
            ovr_seen_q     <= mc_sync[2];
            result_overrun <= mc_sync[2] ^ ovr_seen_q;
        end
    end

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            link_powered <= 1'b0;
            frame_active <= 1'b0;
        end else begin
            link_powered <= mc_sync[1];
            frame_active <= mc_sync[0];
        end
    end

endmodule : ocsq_top

// ==== dv/ocsq_properties.sv ====
// Purpose: port checks of the serial sequencer
// Assumes: sar_code steady while a frame runs
// Notes:   rise_n_q counts link rising edges of the current group
module ocsq_properties (
    input wire logic                        mclk,
    input wire logic                        resetn,
    input wire logic                        chip_select_n,
    input wire logic                        serial_clock,
    input wire logic                        serial_in,
    input wire logic                        serial_out,
    input wire logic                        serial_out_en,
    input wire logic [ocsq_pkg::RES_W-1:0]  sar_code,
    input wire logic                        track_en,
    input wire logic                        hold_en,
    input wire logic [ocsq_pkg::CHAN_W-1:0] mux_channel,
    input wire logic                        powered_up,
    input wire logic                        frame_active
);
    logic [3:0] rise_n_q;
    logic [7:0] word_q;

    // chip select high clears framing, same as the design
    always_ff @(posedge serial_clock or posedge chip_select_n) begin
        if (chip_select_n)
            rise_n_q <= 4'h0;
        else
            rise_n_q <= rise_n_q + 4'h1;
    end

    always_ff @(posedge serial_clock) begin
        word_q <= {word_q[6:0], serial_in};
    end

    ////////////////////////////////////////////////////////////////////
    a_lead_zeros: assert property (
        @(posedge serial_clock) disable iff (chip_select_n || !resetn)
        rise_n_q < 4'h4 |-> !serial_out) else $error("leading bit not zero");
    a_result_bits: assert property (
        @(posedge serial_clock) disable iff (chip_select_n || !resetn)
        rise_n_q > 4'h3 |-> serial_out == sar_code[4'hF - rise_n_q]) else $error("result bit wrong");
    a_track_first: assert property (
        @(posedge serial_clock) disable iff (chip_select_n || !resetn)
        rise_n_q < 4'h3 |-> track_en && !hold_en) else $error("not tracking");
    a_hold_convert: assert property (
        @(posedge serial_clock) disable iff (chip_select_n || !resetn)
        rise_n_q inside {[4'h3:4'hE]} |-> hold_en && !track_en && powered_up) else $error("not holding");
    a_gap_power: assert property (
        @(posedge serial_clock) disable iff (chip_select_n || !resetn)
        rise_n_q == 4'hF |-> !powered_up) else $error("powered in gap");
    a_chan_commit: assert property (
        @(posedge serial_clock) disable iff (chip_select_n || !resetn)
        rise_n_q == 4'h8 |-> mux_channel == word_q[5:3]) else $error("channel not committed");
    a_out_enable: assert property (
        @(posedge mclk) disable iff (!resetn)
        serial_out_en == !chip_select_n) else $error("enable not tied to select");
    a_idle_low: assert property (
        @(posedge mclk) disable iff (!resetn)
        chip_select_n |-> !serial_out) else $error("output busy while idle");
    a_chan_kept: assert property (
        @(posedge mclk) disable iff (!resetn)
        chip_select_n && $past(chip_select_n) |-> $stable(mux_channel)) else $error("channel lost");
    a_frame_seen: assert property (
        @(posedge mclk) disable iff (!resetn)
        $fell(chip_select_n) |-> ##[1:4] frame_active) else $error("frame not seen");
endmodule : ocsq_properties

bind ocsq_top ocsq_properties ocsq_properties_inst (.mclk, .resetn, .chip_select_n, .serial_clock,
    .serial_in, .serial_out, .serial_out_en, .sar_code, .track_en, .hold_en, .mux_channel,
    .powered_up, .frame_active);

// ==== dv/ocsq_host_model.sv ====
// Purpose: serial host that frames and clocks the link
// Assumes: link clock 12 ns, standing still between frames
// Notes:   each 16-bit word seen on serial_out is queued
module ocsq_host_model (
    output logic      chip_select_n,
    output logic      serial_clock,
    output logic      serial_in,
    input  wire logic serial_out
);
    timeunit 1ns;
    timeprecision 100ps;
    logic [15:0] rx_q[$];
    logic [15:0] sh;
    logic [7:0]  word;

    initial begin
        chip_select_n = 1'b1;
        serial_clock = 1'b1;
        serial_in = 1'b0;
    end

    // mode 0: clock high at select, 1: clock low, 2: both fall at once
    task automatic begin_frame(input int mode, input logic [7:0] w);
        word = w;
        serial_clock = (mode != 1);
        #20;
        serial_in = w[7];
        // clock goes first in the same step so the coincident fall is not a race
        if (mode == 2) serial_clock = 1'b0;
        chip_select_n = 1'b0;
        #6;
    endtask : begin_frame

    task automatic run_groups(input int groups);
        if (serial_clock) serial_clock = 1'b0;
        for (int i = 0; i < 16 * groups; i++) begin
            #6 serial_clock = 1'b1;
            sh = {sh[14:0], serial_out};
            if (i % 16 == 15) rx_q.push_back(sh);
            #6 serial_clock = 1'b0;
            // bits beyond the word toggle so stale values cannot pass
            serial_in = (i % 16 == 15) ? word[7] : (i % 16 < 7) ? word[6 - i % 16] : ~serial_in;
        end
    endtask : run_groups

    task automatic end_frame();
        #6 chip_select_n = 1'b1;
        serial_in = ~serial_in;
    endtask : end_frame
endmodule : ocsq_host_model

// ==== dv/testbench.sv ====
// Purpose: self-checking bench of the serial sequencer
// Assumes: results reach mclk within 8 cycles of a frame end
// Notes:   serial side is driven by the host model
module testbench;
    timeunit 1ns;
    timeprecision 100ps;
    logic                          mclk, resetn, chip_select_n, serial_clock, serial_in;
    logic                          serial_out, serial_out_en, track_en, hold_en, powered_up;
    logic                          result_valid, result_overrun, frame_active, link_powered;
    logic [ocsq_pkg::RES_W-1:0]    sar_code;
    logic [ocsq_pkg::CHAN_W-1:0]   mux_channel;
    ocsq_pkg::ocsq_result_s        result, last_res;
    int                            error_cnt = 0, n_tests = 0, cycles = 0, n_ovr = 0;

    ocsq_host_model ocsq_host_model_inst (.chip_select_n, .serial_clock, .serial_in, .serial_out);
    ocsq_top ocsq_top_inst (.mclk, .resetn, .chip_select_n, .serial_clock, .serial_in, .serial_out,
        .serial_out_en, .sar_code, .track_en, .hold_en, .mux_channel, .powered_up, .result_valid,
        .result, .result_overrun, .link_powered, .frame_active);

    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end

    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (result_valid === 1'b1) last_res <= result;
        if (result_overrun === 1'b1) n_ovr <= n_ovr + 1;
        if (cycles == 4000) begin
            error_cnt++;
            results();
        end
    end

    ////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic frame(input int mode, input int groups, input logic [7:0] w, input logic [11:0] code);
        @(negedge mclk);
        sar_code = code;
        ocsq_host_model_inst.begin_frame(mode, w);
        chk("enable", 1, serial_out_en);
        chk("track", mode != 0, track_en);
        ocsq_host_model_inst.run_groups(groups);
        ocsq_host_model_inst.end_frame();
        #1 chk("release", 0, serial_out_en);
        repeat (groups) chk("word", {4'h0, code}, ocsq_host_model_inst.rx_q.pop_front());
        repeat (8) @(negedge mclk);
    endtask : frame

    ////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        chk("idle out", 0, serial_out);
        chk("reset chan", 0, mux_channel);
        chk("no result", 0, result_valid);
        chk("idle power", 0, link_powered);
        $display("test reset done");
    endtask : t_reset

    task automatic t_first();
        frame(1, 1, 8'hEF, 12'hA5C);
        chk("first chan", 0, last_res.chan);
        chk("first code", 12'hA5C, last_res.code);
        chk("next chan", 5, mux_channel);
        $display("test first done");
    endtask : t_first

    task automatic t_chans();
        logic [2:0] prev;
        prev = 3'h5;
        for (int c = 0; c < 8; c++) begin
            frame(c % 3, 1, 8'(c) << 3, 12'(c * 12'h249));
            chk("mux chan", 16'(c), mux_channel);
            chk("result chan", prev, last_res.chan);
            prev = 3'(c);
        end
        $display("test channels done");
    endtask : t_chans

    task automatic t_cont();
        int ovr0;
        ovr0 = n_ovr;
        frame(0, 3, 8'h10, 12'h7E1);
        chk("cont chan", 2, mux_channel);
        chk("cont code", 12'h7E1, last_res.code);
        chk("overrun", 1, n_ovr > ovr0);
        frame(1, 1, 8'h38, 12'h001);
        chk("after chan", 2, last_res.chan);
        $display("test continuous done");
    endtask : t_cont

    task automatic results();
        $display("checks %0d mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : results

    initial begin
        resetn = 1'b0;
        sar_code = 12'h000;
        repeat (3) @(negedge mclk);
        resetn = 1'b1;
        repeat (3) @(negedge mclk);
        t_reset();
        t_first();
        t_chans();
        t_cont();
        results();
    end
endmodule : testbench
